/* hdl/acdc_top.sv */
// Converter control: compare gating, fault brake, acquisition timing,
// external trigger delay and digital input disconnect.
// Assumes core_clk_i is the divided converter clock; the analog core and
// compare value are on the same clock, trigger and pins are asynchronous.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module acdc_top
  import acdc_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  // Analog core
  input  wire logic                  core_done_i,
  input  wire logic [ACDC_RES_W-1:0] core_result_i,
  input  wire logic [ACDC_RES_W-1:0] compare_value_i,
  output logic                       sample_o,
  output logic                       conv_go_o,
  output logic [ACDC_RES_W-1:0]      conversion_result_o,
  // Trigger, PWM and pins
  input  wire logic                  ext_trig_i,
  output logic                       fault_brake_o,
  output logic                       pwm_run_bit_o,
  input  wire logic [7:0]            ain_pin_i,
  output logic [7:0]                 ain_digital_o,
  // Interrupt
  output logic                       irq_o
);

  acdc_state_e               state_q;
  logic [7:0]                ctrl2_q;
  logic [7:0]                dly_lo_q;
  logic [7:0]                dids_q;
  logic                      ext_sel_q;
  logic [ACDC_EVT_W-1:0]     stat_q;
  logic [ACDC_EVT_W-1:0]     mask_q;
  logic [ACDC_DLY_W-1:0]     dly_cnt_q;
  logic [ACDC_SCNT_W-1:0]    smp_cnt_q;
  logic [2:0]                trig_sync_q;
  logic [7:0]                pin_meta_q;
  logic [7:0]                pin_sync_q;
  logic                      wr_ctrl2;
  logic                      wr_dly;
  logic                      wr_run;
  logic                      wr_stat;
  logic                      wr_mask;
  logic                      wr_dids;
  logic                      sw_start;
  logic                      ext_edge;
  logic                      busy;
  logic                      conv_end;
  logic                      gate_en;
  logic                      match;
  logic                      brake_set;
  logic [ACDC_EVT_W-1:0]     evt_set;
  logic [ACDC_EVT_W-1:0]     evt_clr;
  logic [ACDC_DLY_W-1:0]     dly_total;
  logic [ACDC_SCNT_W-1:0]    smp_total;

  acdc_cmp_if cmp_bus ();

  acdc_cmp u_cmp (
    .cmp_if (cmp_bus)
  );

  // Full 12-bit result compared as it arrives from the core
  assign cmp_bus.result   = core_result_i;
  assign cmp_bus.limit    = compare_value_i;
  assign cmp_bus.polarity = ctrl2_q[ACDC_B_POL];
  assign match            = cmp_bus.match;

  // Register decode
  assign wr_ctrl2 = reg_wr_i && (reg_addr_i == ACDC_OFS_CTRL2);
  assign wr_dly   = reg_wr_i && (reg_addr_i == ACDC_OFS_DLYLO);
  assign wr_run   = reg_wr_i && (reg_addr_i == ACDC_OFS_RUNCTL);
  assign wr_stat  = reg_wr_i && (reg_addr_i == ACDC_OFS_STAT);
  assign wr_mask  = reg_wr_i && (reg_addr_i == ACDC_OFS_MASK);
  assign wr_dids  = reg_wr_i && (reg_addr_i == ACDC_OFS_DIDS);

  assign busy     = (state_q != ACDC_ST_IDLE);
  assign sw_start = wr_run && reg_wdata_i[ACDC_B_BUSY] && !busy;
  assign ext_edge = trig_sync_q[1] && !trig_sync_q[2];
  assign conv_end = (state_q == ACDC_ST_CONV) && core_done_i;
  assign gate_en  = ctrl2_q[ACDC_B_GATE];

  // Longest sampling phase is 34 clocks, hence six counter bits
  assign dly_total = {ctrl2_q[ACDC_B_DLY8], dly_lo_q};
  assign smp_total = ACDC_SCNT_W'({ctrl2_q[ACDC_B_AQT_H:ACDC_B_AQT_L], 2'b00})
                     + ACDC_AQT_BASE;

  assign brake_set = ctrl2_q[ACDC_B_FBEN] && ctrl2_q[ACDC_B_CMPO];

  // Done event only on match when gating is on
  assign evt_set[ACDC_B_DONE]  = conv_end && (!gate_en || match);
  assign evt_set[ACDC_B_BRAKE] = brake_set && !fault_brake_o;
  assign evt_clr = wr_stat ? reg_wdata_i[ACDC_EVT_W-1:0] : '0;

  // Trigger synchroniser, third stage for edge detection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_sync_q <= 3'h0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trig_i};
    end
  end

  // Control register two and delay low byte
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl2_q  <= ACDC_RST_CTRL2;
      dly_lo_q <= ACDC_RST_DLYLO;
    end else begin
      if (wr_ctrl2) begin
        ctrl2_q[ACDC_B_FBEN]                <= reg_wdata_i[ACDC_B_FBEN];
        ctrl2_q[ACDC_B_POL]                 <= reg_wdata_i[ACDC_B_POL];
        ctrl2_q[ACDC_B_GATE]                <= reg_wdata_i[ACDC_B_GATE];
        ctrl2_q[ACDC_B_AQT_H:ACDC_B_AQT_L]  <= reg_wdata_i[ACDC_B_AQT_H:ACDC_B_AQT_L];
        ctrl2_q[ACDC_B_DLY8]                <= reg_wdata_i[ACDC_B_DLY8];
      end
      if (conv_end) begin
        ctrl2_q[ACDC_B_CMPO] <= match;
      end
      if (wr_dly) begin
        dly_lo_q <= reg_wdata_i;
      end
    end
  end

  // Run control, disconnect, mask
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sel_q <= 1'b0;
      dids_q    <= ACDC_RST_DIDS;
      mask_q    <= '0;
    end else begin
      if (wr_run) begin
        ext_sel_q <= reg_wdata_i[ACDC_B_EXTS];
      end
      if (wr_dids) begin
        dids_q <= reg_wdata_i;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata_i[ACDC_EVT_W-1:0];
      end
    end
  end

  // PWM run bit and fault brake
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_run_bit_o <= 1'b0;
      fault_brake_o <= 1'b0;
    end else begin
      // Brake keeps run low until enable or compare output drops
      fault_brake_o <= brake_set;
      if (brake_set) begin
        pwm_run_bit_o <= 1'b0;
      end else if (wr_run) begin
        pwm_run_bit_o <= reg_wdata_i[ACDC_B_RUN];
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~evt_clr) | evt_set;
      irq_o  <= |(((stat_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  // Conversion sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= ACDC_ST_IDLE;
      dly_cnt_q <= ACDC_DLY_ZERO;
      smp_cnt_q <= ACDC_SCNT_ONE;
      sample_o  <= 1'b0;
      conv_go_o <= 1'b0;
    end else begin
      conv_go_o <= 1'b0;
      case (state_q)
        ACDC_ST_IDLE: begin
          if (sw_start) begin
            state_q   <= ACDC_ST_SAMPLE;
            smp_cnt_q <= smp_total;
            sample_o  <= 1'b1;
          end else if (ext_sel_q && ext_edge) begin
            if (dly_total == ACDC_DLY_ZERO) begin
              state_q   <= ACDC_ST_SAMPLE;
              smp_cnt_q <= smp_total;
              sample_o  <= 1'b1;
            end else begin
              state_q   <= ACDC_ST_DELAY;
              dly_cnt_q <= dly_total;
            end
          end
        end
        ACDC_ST_DELAY: begin
          // Further triggers are not looked at outside idle
          if (dly_cnt_q == ACDC_DLY_ONE) begin
            state_q   <= ACDC_ST_SAMPLE;
            smp_cnt_q <= smp_total;
            sample_o  <= 1'b1;
          end
          dly_cnt_q <= dly_cnt_q - ACDC_DLY_ONE;
        end
        ACDC_ST_SAMPLE: begin
          if (smp_cnt_q == ACDC_SCNT_ONE) begin
            state_q   <= ACDC_ST_CONV;
            sample_o  <= 1'b0;
            conv_go_o <= 1'b1;
          end else begin
            smp_cnt_q <= smp_cnt_q - ACDC_SCNT_ONE;
          end
        end
        ACDC_ST_CONV: begin
          if (core_done_i) begin
            if (gate_en && !match) begin
              state_q   <= ACDC_ST_SAMPLE;
              smp_cnt_q <= smp_total;
              sample_o  <= 1'b1;
            end else begin
              state_q <= ACDC_ST_IDLE;
            end
          end
        end
        default: begin
          state_q  <= ACDC_ST_IDLE;
          sample_o <= 1'b0;
        end
      endcase
    end
  end

  // Result register updated after each conversion
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_result_o <= '0;
    end else if (conv_end) begin
      conversion_result_o <= core_result_i;
    end
  end

  // Pin synchroniser and digital input gating
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_q    <= 8'h00;
      pin_sync_q    <= 8'h00;
      ain_digital_o <= 8'h00;
    end else begin
      pin_meta_q    <= ain_pin_i;
      pin_sync_q    <= pin_meta_q;
      ain_digital_o <= pin_sync_q & ~dids_q;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= ACDC_RST_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ACDC_OFS_CTRL2:  reg_rdata_o <= ctrl2_q;
        ACDC_OFS_DLYLO:  reg_rdata_o <= dly_lo_q;
        ACDC_OFS_RUNCTL: reg_rdata_o <= {5'h00, pwm_run_bit_o, ext_sel_q, busy};
        ACDC_OFS_STAT:   reg_rdata_o <= {6'h00, stat_q};
        ACDC_OFS_MASK:   reg_rdata_o <= {6'h00, mask_q};
        ACDC_OFS_DIDS:   reg_rdata_o <= dids_q;
        default:         reg_rdata_o <= ACDC_RST_ZERO;
      endcase
    end else begin
      reg_rdata_o <= ACDC_RST_ZERO;
    end
  end

endmodule

/* hdl/acdc_pkg.sv */
// Shared constants for the converter compare and trigger delay control block.
// Assumes an 8-bit special function register port and one converter clock.
package acdc_pkg;

  // Register offsets
  localparam logic [7:0] ACDC_OFS_CTRL2  = 8'hE2;
  localparam logic [7:0] ACDC_OFS_DLYLO  = 8'hE3;
  localparam logic [7:0] ACDC_OFS_RUNCTL = 8'hE4;
  localparam logic [7:0] ACDC_OFS_STAT   = 8'hE5;
  localparam logic [7:0] ACDC_OFS_MASK   = 8'hE6;
  localparam logic [7:0] ACDC_OFS_DIDS   = 8'hF6;

  // Reset values
  localparam logic [7:0] ACDC_RST_CTRL2 = 8'h00;
  localparam logic [7:0] ACDC_RST_DLYLO = 8'h00;
  localparam logic [7:0] ACDC_RST_DIDS  = 8'h00;
  localparam logic [7:0] ACDC_RST_ZERO  = 8'h00;

  // Fields of converter_control_two
  localparam int ACDC_B_FBEN  = 7;
  localparam int ACDC_B_POL   = 6;
  localparam int ACDC_B_GATE  = 5;
  localparam int ACDC_B_CMPO  = 4;
  localparam int ACDC_B_AQT_H = 3;
  localparam int ACDC_B_AQT_L = 1;
  localparam int ACDC_B_DLY8  = 0;

  // Fields of the run control register
  localparam int ACDC_B_BUSY  = 0;
  localparam int ACDC_B_EXTS  = 1;
  localparam int ACDC_B_RUN   = 2;

  // Fields of status and mask
  localparam int ACDC_B_DONE  = 0;
  localparam int ACDC_B_BRAKE = 1;
  localparam int ACDC_EVT_W   = 2;

  // Widths and timing
  localparam int ACDC_RES_W   = 12;
  localparam int ACDC_DLY_W   = 9;
  localparam int ACDC_AQT_W   = 3;
  localparam int ACDC_SCNT_W  = 6;
  localparam int ACDC_AQT_SH  = 2;
  localparam logic [ACDC_SCNT_W-1:0] ACDC_AQT_BASE = 6'h06;
  localparam logic [ACDC_SCNT_W-1:0] ACDC_SCNT_ONE = 6'h01;
  localparam logic [ACDC_DLY_W-1:0]  ACDC_DLY_ZERO = 9'h000;
  localparam logic [ACDC_DLY_W-1:0]  ACDC_DLY_ONE  = 9'h001;

  typedef enum logic [3:0] {
    ACDC_ST_IDLE   = 4'h1,
    ACDC_ST_DELAY  = 4'h2,
    ACDC_ST_SAMPLE = 4'h4,
    ACDC_ST_CONV   = 4'h8
  } acdc_state_e;

endpackage

/* hdl/acdc_cmp_if.sv */
// Carries the result comparator operands and its verdict.
// Assumes both ends sit on the converter clock.
`timescale 1ns/1ps
interface acdc_cmp_if;
  import acdc_pkg::*;
  logic [ACDC_RES_W-1:0] result;
  logic [ACDC_RES_W-1:0] limit;
  logic                  polarity;
  logic                  match;

  modport cmp  (input result, input limit, input polarity, output match);
  modport user (output result, output limit, output polarity, input match);
endinterface

/* hdl/acdc_cmp.sv */
// Twelve-bit result comparator with selectable polarity.
// Assumes operands are stable in the cycle the verdict is used.
`timescale 1ns/1ps
module acdc_cmp
  import acdc_pkg::*;
(
  // Operands and verdict
  acdc_cmp_if.cmp cmp_if
);

  always_comb begin
    if (cmp_if.polarity) begin
      cmp_if.match = (cmp_if.result < cmp_if.limit);
    end else begin
      cmp_if.match = (cmp_if.result >= cmp_if.limit);
    end
  end

endmodule

/* bench/acdc_core_model.sv */
// Analog core stand-in: answers each start pulse after a set latency.
// Assumes start and done share the converter clock.
`timescale 1ns/1ps
module acdc_core_model
  import acdc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control from the bench and the block
  input  wire logic                  go_i,
  input  wire logic [ACDC_RES_W-1:0] value_i,
  input  wire logic [3:0]            lat_i,
  // Answer
  output logic                       done_o,
  output logic [ACDC_RES_W-1:0]      result_o
);
  int cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      result_o <= '0;
    end else begin
      done_o <= 1'b0;
      // Result only valid with done; otherwise inverted junk
      result_o <= ~value_i;
      if (go_i) begin
        cnt <= int'(lat_i) + 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        done_o <= 1'b1;
        result_o <= value_i;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

/* bench/acdc_chk.sv */
// Port checks for the converter control block.
// Assumes a bind from the bench top and a single clock domain.
`timescale 1ns/1ps
module acdc_chk
  import acdc_pkg::*;
(
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire logic                  reg_rd_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  core_done_i,
  input wire logic [ACDC_RES_W-1:0] core_result_i,
  input wire logic                  sample_o,
  input wire logic                  conv_go_o,
  input wire logic [ACDC_RES_W-1:0] conversion_result_o,
  input wire logic                  fault_brake_o,
  input wire logic                  pwm_run_bit_o,
  input wire logic [7:0]            ain_pin_i,
  input wire logic [7:0]            ain_digital_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  brake_stops_run_a: assert property (fault_brake_o |-> !pwm_run_bit_o)
    else $error("brake high while pwm run set");
  sample_min_a: assert property ($rose(sample_o) |-> sample_o [*6])
    else $error("sampling phase shorter than six cycles");
  go_after_sample_a: assert property ($fell(sample_o) |-> conv_go_o)
    else $error("no start pulse at end of sampling");
  go_pulse_shape_a: assert property (
    conv_go_o |-> $past(sample_o) && !sample_o ##1 !conv_go_o && !sample_o)
    else $error("start pulse malformed");
  result_load_a: assert property (
    core_done_i |=> conversion_result_o == $past(core_result_i))
    else $error("result not loaded from core");
  result_hold_a: assert property ($changed(conversion_result_o) |-> $past(core_done_i))
    else $error("result changed without completion");
  pin_masked_a: assert property ((ain_digital_o & ~$past(ain_pin_i, 3)) == 8'h00)
    else $error("digital input high without pin high");
  read_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the core stand-in model and the bound port checker.
`timescale 1ns/1ps
module tb_top
  import acdc_pkg::*;
;
  logic        clk, rst, wr, rd, go, done, trig, samp, brake, run, irq, psamp;
  logic [7:0]  addr, wdata, rdata, pins, dig, d;
  logic [11:0] res, cmpv, cval, cres;
  logic [3:0]  lat;
  logic [31:0] lfsr;
  logic [7:0]  ra [4] = '{ACDC_OFS_CTRL2, ACDC_OFS_DLYLO, ACDC_OFS_DIDS, 8'h10};
  int          fails, num_checks, gos, dones, rises, n, b;

  acdc_top dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .core_done_i(done),
    .core_result_i(cres), .compare_value_i(cmpv), .sample_o(samp), .conv_go_o(go),
    .conversion_result_o(res), .ext_trig_i(trig), .fault_brake_o(brake),
    .pwm_run_bit_o(run), .ain_pin_i(pins), .ain_digital_o(dig), .irq_o(irq));
  acdc_core_model core (.clk_i(clk), .rst_i(rst), .go_i(go), .value_i(cval),
    .lat_i(lat), .done_o(done), .result_o(cres));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    psamp <= samp;
    if (go) gos++;
    if (done) dones++;
    if (samp && !psamp) rises++;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One software-started conversion with gating off
  task automatic conv(input logic [7:0] c, input logic [7:0] r, input logic [11:0] v);
    int         k;
    logic [7:0] q;
    logic       cm;
    cval <= v;
    wreg(ACDC_OFS_CTRL2, c);
    wreg(ACDC_OFS_RUNCTL, r);
    for (k = 0; k < 20 && !samp; k++) tick;
    // First high cycle already passed while waiting for the rise
    for (k = 1; k < 40 && samp; k++) tick;
    chk(12'(k), 12'(4 * c[3:1] + 6));
    for (k = 0; k < 40 && !done; k++) tick;
    tick;
    chk(res, v);
    cm = c[6] ? (v < cmpv) : (v >= cmpv);
    rreg(ACDC_OFS_CTRL2, q);
    chk(12'(q), 12'({c[7:5], cm, c[3:0]}));
    rreg(ACDC_OFS_STAT, q);
    chk(12'({q[1:0], irq}), 12'({c[7], 2'b11}));
    wreg(ACDC_OFS_STAT, 8'hFF);
    repeat (2) tick;
    chk(12'(irq), 12'h000);
  endtask

  initial begin
    rst = 1'b1;
    {wr, rd, trig} = 3'b000;
    {addr, wdata, pins} = 24'h000000;
    {cmpv, cval} = 24'h000000;
    lat = 4'h0;
    lfsr = 32'h0FF3C668;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rreg(ra[i], d);
      chk(12'(d), 12'h000);
    end
    wreg(ACDC_OFS_DLYLO, 8'hA5);
    wreg(ACDC_OFS_CTRL2, 8'hFF);
    wreg(8'h10, 8'hFF);
    rreg(ACDC_OFS_DLYLO, d);
    chk(12'(d), 12'h0A5);
    rreg(ACDC_OFS_CTRL2, d);
    chk(12'(d), 12'h0EF);
    rreg(8'h10, d);
    chk(12'(d), 12'h000);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wreg(ACDC_OFS_DIDS, lfsr[7:0]);
      pins <= lfsr[15:8];
      repeat (4) tick;
      chk(12'(dig), 12'(lfsr[15:8] & ~lfsr[7:0]));
    end
    wreg(ACDC_OFS_MASK, 8'h03);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      lat <= lfsr[31:28];
      cmpv <= lfsr[27:16];
      // Last two runs sit exactly on the compare value
      conv({1'b0, (i > 5) ? i[0] : lfsr[0], 2'b00, 3'(i), 1'b0}, 8'h01,
           (i > 5) ? lfsr[27:16] : lfsr[11:0]);
    end
    // Gated: two misses, then a match ends the run
    cmpv <= 12'h800;
    cval <= 12'h100;
    b = dones;
    n = gos;
    wreg(ACDC_OFS_CTRL2, 8'h20);
    wreg(ACDC_OFS_RUNCTL, 8'h01);
    for (int k = 0; k < 200 && dones < b + 2; k++) tick;
    cval <= 12'hC00;
    rreg(ACDC_OFS_STAT, d);
    chk(12'(d), 12'h000);
    for (int k = 0; k < 40 && !d[0]; k++) rreg(ACDC_OFS_STAT, d);
    chk(12'(gos - n), 12'h003);
    chk(res, 12'hC00);
    wreg(ACDC_OFS_STAT, 8'hFF);
    // Brake on match
    cmpv <= 12'h000;
    wreg(ACDC_OFS_RUNCTL, 8'h04);
    tick;
    chk(12'(run), 12'h001);
    conv(8'h80, 8'h05, 12'h123);
    chk(12'({brake, run}), 12'h002);
    wreg(ACDC_OFS_RUNCTL, 8'h04);
    tick;
    chk(12'(run), 12'h000);
    wreg(ACDC_OFS_CTRL2, 8'h00);
    wreg(ACDC_OFS_RUNCTL, 8'h04);
    repeat (2) tick;
    chk(12'({brake, run}), 12'h001);
    // External trigger, 9-bit delay of 258
    wreg(ACDC_OFS_DLYLO, 8'h02);
    wreg(ACDC_OFS_CTRL2, 8'h01);
    wreg(ACDC_OFS_RUNCTL, 8'h02);
    b = rises;
    @(posedge clk) trig <= 1'b1;
    for (n = 0; n < 400 && !samp; n++) tick;
    chk(12'(n >= 258 && n <= 264), 12'h001);
    trig <= 1'b0;
    repeat (3) tick;
    trig <= 1'b1;
    for (n = 0; n < 400 && !done; n++) tick;
    repeat (300) tick;
    chk(12'(rises - b), 12'h001);
    complete_run;
  end

  initial begin
    #500000;
    fails++;
    complete_run;
  end
endmodule

bind acdc_top acdc_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .core_done_i(core_done_i), .core_result_i(core_result_i),
  .sample_o(sample_o), .conv_go_o(conv_go_o), .conversion_result_o(conversion_result_o),
  .fault_brake_o(fault_brake_o), .pwm_run_bit_o(pwm_run_bit_o), .ain_pin_i(ain_pin_i),
  .ain_digital_o(ain_digital_o));
